// file: src/sram_port_consts.svh
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH
`define SRAM_ADDR_W      19
`define SRAM_DATA_W      8
`define SRAM_CLK_PS      20000
// read cycle, write pulse, address setup, recovery, output release (ps)
`define SRAM_T_RC_PS     100000
`define SRAM_T_WP_PS     60000
`define SRAM_T_AS_PS     20000
`define SRAM_T_WR_PS     5000
`define SRAM_T_HZ_PS     35000
`define CYC_UP(t) (((t) + `SRAM_CLK_PS - 1) / `SRAM_CLK_PS)
`define SRAM_RD_CYC      `CYC_UP(`SRAM_T_RC_PS)
`define SRAM_WP_CYC      `CYC_UP(`SRAM_T_WP_PS)
`define SRAM_AS_CYC      `CYC_UP(`SRAM_T_AS_PS)
`define SRAM_WR_CYC      `CYC_UP(`SRAM_T_WR_PS)
`define SRAM_HZ_CYC      `CYC_UP(`SRAM_T_HZ_PS)
`endif

// file: src/sram_port_pkg.sv
package sram_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WSET  = 3'b010,
    ST_WPULS = 3'b011,
    ST_WREC  = 3'b100,
    ST_TURN  = 3'b101
  } state_e;
endpackage : sram_port_pkg

// file: src/sram_host_ctrl.sv
`timescale 1ns/10ps
`include "sram_port_consts.svh"
module sram_host_ctrl #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W
) (
  input  wire logic              clk_sys,                // 50 mhz system clock
  input  wire logic              rst_b,                  // sync reset, low active
  input  wire logic              clk_en,                 // low freezes all state
  input  wire logic              req_valid,              // access request
  output logic                   req_ready,              // request taken when both high
  input  wire logic              req_write,              // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr,               // byte location
  input  wire logic [DATA_W-1:0] req_wdata,              // write byte
  output logic                   rsp_valid,              // read byte pulse
  output logic [DATA_W-1:0]      rsp_rdata,              // read byte
  output logic [ADDR_W-1:0]      location_select_lines,  // address pins
  output logic                   select_active_low_b,    // low chip select
  output logic                   select_active_high,     // high chip select
  output logic                   out_enable_b,           // output enable, low active
  output logic                   write_strobe_b,         // write strobe, low active
  input  wire logic [DATA_W-1:0] byte_lanes_in,          // lane level seen
  output logic [DATA_W-1:0]      byte_lanes_out,         // lane drive value
  output logic [DATA_W-1:0]      byte_lanes_oe           // high while we drive
);
  localparam logic [3:0] RD_N = 4'(`SRAM_RD_CYC + 2);  // two extra for input sync
  localparam logic [3:0] WP_N = 4'(`SRAM_WP_CYC);
  localparam logic [3:0] AS_N = 4'(`SRAM_AS_CYC);
  localparam logic [3:0] WR_N = 4'(`SRAM_WR_CYC);
  localparam logic [3:0] HZ_N = 4'(`SRAM_HZ_CYC);

  // ************************************************************
  // lane input synchroniser
  // ************************************************************
  logic [DATA_W-1:0] lane_s1_reg;
  logic [DATA_W-1:0] lane_s2_reg;

  // pins are asynchronous to clk_sys, two flops before use
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      lane_s1_reg <= '0;
      lane_s2_reg <= '0;
    end
    else if (clk_en)
    begin
      lane_s1_reg <= byte_lanes_in;
      lane_s2_reg <= lane_s1_reg;
    end
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  sram_port_pkg::state_e state_reg, state_next;
  logic [3:0]            cnt_reg, cnt_next;
  logic [ADDR_W-1:0]     addr_reg, addr_next;
  logic [DATA_W-1:0]     wdata_reg, wdata_next;
  logic [DATA_W-1:0]     rdata_reg, rdata_next;
  logic                  rvalid_reg, rvalid_next;
  logic                  sel_reg, sel_next;
  logic                  oe_b_reg, oe_b_next;
  logic                  we_b_reg, we_b_next;
  logic                  drive_reg, drive_next;

  assign req_ready = (state_reg == sram_port_pkg::ST_IDLE) && clk_en;

  // next state: reads hold oe low, writes keep oe high throughout
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    sel_next    = sel_reg;
    oe_b_next   = oe_b_reg;
    we_b_next   = we_b_reg;
    drive_next  = drive_reg;
    case (state_reg)
      sram_port_pkg::ST_IDLE:
      begin
        sel_next   = 1'b0;                  // deselect idles the memory
        oe_b_next  = 1'b1;
        we_b_next  = 1'b1;
        drive_next = 1'b0;
        if (req_valid)
        begin
          addr_next  = req_addr;            // one location per access
          wdata_next = req_wdata;
          sel_next   = 1'b1;                // both selects active together
          cnt_next   = 4'h0;
          if (req_write)
          begin
            oe_b_next = 1'b1;               // memory stays floating
            state_next = sram_port_pkg::ST_WSET;
          end
          else
          begin
            oe_b_next = 1'b0;               // memory drives the byte
            state_next = sram_port_pkg::ST_READ;
          end
        end
      end
      sram_port_pkg::ST_READ:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == RD_N - 4'h1)
        begin
          rdata_next  = lane_s2_reg;        // byte from the lanes
          rvalid_next = 1'b1;
          sel_next    = 1'b0;
          oe_b_next   = 1'b1;
          cnt_next    = 4'h0;
          state_next  = sram_port_pkg::ST_TURN;
        end
      end
      sram_port_pkg::ST_WSET:
      begin
        // address settles; lanes only driven once memory output is released
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == AS_N - 4'h1)
        begin
          drive_next = 1'b1;                // never against memory output
          we_b_next  = 1'b0;                // store whatever the lanes show
          cnt_next   = 4'h0;
          state_next = sram_port_pkg::ST_WPULS;
        end
      end
      sram_port_pkg::ST_WPULS:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == WP_N - 4'h1)
        begin
          we_b_next  = 1'b1;                // strobe rise ends the write
          cnt_next   = 4'h0;
          state_next = sram_port_pkg::ST_WREC;
        end
      end
      sram_port_pkg::ST_WREC:
      begin
        // data held past the ending edge, then deselect
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == WR_N - 4'h1)
        begin
          drive_next = 1'b0;
          sel_next   = 1'b0;
          cnt_next   = 4'h0;
          state_next = sram_port_pkg::ST_IDLE;
        end
      end
      sram_port_pkg::ST_TURN:
      begin
        // wait for memory output to float before any write may drive
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == HZ_N - 4'h1)
        begin
          cnt_next   = 4'h0;
          state_next = sram_port_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = sram_port_pkg::ST_IDLE;
      end
    endcase
  end

  // register stage only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg  <= sram_port_pkg::ST_IDLE;
      cnt_reg    <= 4'h0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      sel_reg    <= 1'b0;
      oe_b_reg   <= 1'b1;
      we_b_reg   <= 1'b1;
      drive_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      sel_reg    <= sel_next;
      oe_b_reg   <= oe_b_next;
      we_b_reg   <= we_b_next;
      drive_reg  <= drive_next;
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  assign location_select_lines = addr_reg;
  assign select_active_low_b   = ~sel_reg;
  assign select_active_high    = sel_reg;
  assign out_enable_b          = oe_b_reg;
  assign write_strobe_b        = we_b_reg;
  assign byte_lanes_out        = wdata_reg;
  assign byte_lanes_oe         = {DATA_W{drive_reg}};
  assign rsp_valid             = rvalid_reg;
  assign rsp_rdata             = rdata_reg;
endmodule : sram_host_ctrl

// file: testbench/sram_ctrl_monitor.sv
`timescale 1ns/10ps
// ***********
// pin checker
// ***********
module sram_ctrl_monitor #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input wire logic              clk_sys,               // clock
  input wire logic              rst_b,                 // reset
  input wire logic [ADDR_W-1:0] location_select_lines, // address
  input wire logic              select_active_low_b,   // low select
  input wire logic              select_active_high,    // high select
  input wire logic              out_enable_b,          // read enable
  input wire logic              write_strobe_b,        // strobe
  input wire logic [DATA_W-1:0] byte_lanes_oe          // drive enables
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // strobes only ever move inside a full select
  chk_wr_sel: assert property (
    !write_strobe_b |-> !select_active_low_b && select_active_high) else $error("wr sel");
  chk_rd_sel: assert property (
    !out_enable_b |-> !select_active_low_b && select_active_high && write_strobe_b)
    else $error("rd sel");
  chk_rd_hold: assert property (
    $fell(out_enable_b) |-> !out_enable_b[*7] ##1 out_enable_b) else $error("rd len");
  chk_wr_len: assert property (
    $fell(write_strobe_b) |-> !write_strobe_b[*3] ##1 write_strobe_b) else $error("wr len");
  chk_wr_end: assert property (
    $rose(write_strobe_b) |-> &byte_lanes_oe && !select_active_low_b) else $error("wr end");
  chk_no_clash: assert property (
    |byte_lanes_oe |-> out_enable_b) else $error("lane clash");
  chk_oe_wr: assert property (
    !write_strobe_b |-> out_enable_b && &byte_lanes_oe) else $error("oe in write");
  chk_addr_hold: assert property (
    !select_active_low_b && !$past(select_active_low_b) |-> $stable(location_select_lines))
    else $error("addr moved");
endmodule : sram_ctrl_monitor

bind sram_host_ctrl sram_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .location_select_lines(location_select_lines),
  .select_active_low_b(select_active_low_b), .select_active_high(select_active_high),
  .out_enable_b(out_enable_b), .write_strobe_b(write_strobe_b), .byte_lanes_oe(byte_lanes_oe));

// file: testbench/sram_far_model.sv
`timescale 1ns/10ps
// ****************
// far side memory
// ****************
module sram_far_model (
  input  wire logic [18:0] addr,    // location lines
  input  wire logic        sel_b,   // low select
  input  wire logic        sel_h,   // high select
  input  wire logic        oe_b,    // output enable
  input  wire logic        we_b,    // write strobe
  input  wire logic [7:0]  host_d,  // host drive value
  input  wire logic [7:0]  host_oe, // host enables
  output logic      [7:0]  lane     // resolved lanes
);
  logic [7:0] mem [logic [18:0]]; // one byte per location
  logic [7:0] flt = 8'h3c;
  logic       sel, drv, wr;
  logic       wr_seen = 1'b0;
  // no pull: a floating lane wanders so nobody can lean on it
  always #7 flt = ~flt;
  assign sel = !sel_b && sel_h;
  assign wr  = sel && !we_b;
  assign drv = sel && !oe_b && we_b;
  // byte taken when the overlap ends, whichever pin ends it; the pins
  // settling out of unknown at power up must not count as a write
  always @(wr)
  begin
    if (wr_seen && wr === 1'b0)
      mem[addr] = lane;
    wr_seen = (wr === 1'b1);
  end
  assign lane = &host_oe ? host_d : drv ? mem[addr] : flt;
endmodule : sram_far_model

// file: testbench/sram_host_ctrl_tb.sv
`timescale 1ns/10ps
// *********
// port bench
// *********
module sram_host_ctrl_tb;
  logic        clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        clk_en = 1'b1;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        ready, rsp_valid, sel_b, sel_h, oe_b, we_b;
  logic [18:0] addr;
  logic [7:0]  rdata, lane, d_out, d_oe;
  int          err_count = 0, check_count = 0;
  // 50 mhz clock
  always #10 clk_sys = ~clk_sys;
  sram_host_ctrl dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rdata),
    .location_select_lines(addr), .select_active_low_b(sel_b), .select_active_high(sel_h),
    .out_enable_b(oe_b), .write_strobe_b(we_b), .byte_lanes_in(lane),
    .byte_lanes_out(d_out), .byte_lanes_oe(d_oe));
  sram_far_model mem_u (.addr(addr), .sel_b(sel_b), .sel_h(sel_h), .oe_b(oe_b),
    .we_b(we_b), .host_d(d_out), .host_oe(d_oe), .lane(lane));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one access; for a read d is the byte expected back
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int n, m;
    n = 0;
    m = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    @(negedge clk_sys);
    while (ready !== 1'b1 && n < 40) @(negedge clk_sys) n++;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    while (!wr && rsp_valid !== 1'b1 && m < 40) @(negedge clk_sys) m++;
    if (n >= 40 || m >= 40)
    begin
      err_count++;
      print_verdict();
    end
    if (!wr) check("read latency", 19'h00008, 19'(m));
    if (!wr) check("read byte", {11'h000, d}, {11'h000, rdata});
    if (!wr) @(negedge clk_sys);
    if (!wr) check("rsp pulse", 19'h00000, 19'(rsp_valid));
  endtask : access
  // drive one request and return at the edge that takes it
  task automatic take(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    @(negedge clk_sys);
    while (ready !== 1'b1 && n < 40) @(negedge clk_sys) n++;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (n >= 40)
    begin
      err_count++;
      print_verdict();
    end
  endtask : take
  // clock enable low holds the write recovery as it stands, then it resumes
  task automatic test_freeze();
    take(1'b1, 19'h0f0f0, 8'hc3);
    repeat (4) @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check("frozen pins", 19'h007ff, 19'({ready, sel_b, sel_h, oe_b, we_b, d_oe}));
    @(posedge clk_sys);
    clk_en <= 1'b1;
    access(1'b0, 19'h0f0f0, 8'hc3);
    $display("test freeze done");
  endtask : test_freeze
  // reset in mid write pulse drops every pin to idle, then access resumes
  task automatic test_reset_mid();
    take(1'b1, 19'h33333, 8'h0f);
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check("reset pins", 19'h01b00, 19'({ready, sel_b, sel_h, oe_b, we_b, d_oe}));
    access(1'b0, 19'h7ffff, 8'h69);
    $display("test reset mid done");
  endtask : test_reset_mid
  // end addresses and alternating bit patterns
  task automatic test_edges();
    logic [18:0] a [4] = '{19'h00000, 19'h7ffff, 19'h55555, 19'h2aaaa};
    foreach (a[i]) access(1'b1, a[i], a[i][7:0] ^ 8'h96);
    foreach (a[i]) access(1'b0, a[i], a[i][7:0] ^ 8'h96);
    $display("test edges done");
  endtask : test_edges
  // back to back writes to one place, last one wins
  task automatic test_rewrite();
    access(1'b1, 19'h1234a, 8'ha5);
    access(1'b1, 19'h1234a, 8'h5a);
    access(1'b0, 19'h1234a, 8'h5a);
    access(1'b0, 19'h7ffff, 8'h69);
    $display("test rewrite done");
  endtask : test_rewrite
  // reset held 16 cycles, then the pins must be idle
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check("idle pins", 19'h00b00, 19'({sel_b, sel_h, oe_b, we_b, d_oe}));
    $display("test reset done");
    test_edges();
    test_rewrite();
    test_freeze();
    test_reset_mid();
    print_verdict();
  end
endmodule : sram_host_ctrl_tb
